// ===== rtl/khc_defs.svh
`ifndef KHC_DEFS_SVH
`define KHC_DEFS_SVH
`define KHC_CMD_DEFAULT  8'hF6
`define KHC_CMD_ALL_LO   8'hF7
`define KHC_CMD_ALL_HI   8'hFA
`define KHC_CMD_KEY_LO   8'hFB
`define KHC_CMD_KEY_HI   8'hFD
`define KHC_CMD_RESEND   8'hFE
`define KHC_CMD_RESET    8'hFF
`define KHC_CMD_ECHO     8'hEE
`define KHC_BAD_A        8'hEF
`define KHC_BAD_B        8'hF1
`define KHC_RSP_ACK      8'hFA
`define KHC_RSP_PASS     8'hAA
`define KHC_RSP_FAIL     8'hFC
`define KHC_RSP_ECHO     8'hEE
`define KHC_SET_POWERON  2'h2
`define KHC_ACCEPT_US    500
`define KHC_CLK_MHZ      50
`define KHC_ACCEPT_CYC   (`KHC_ACCEPT_US * `KHC_CLK_MHZ)
`define KHC_SELF_CYC     16
`endif

// ===== rtl/khc_pkg.sv
package khc_pkg;
    typedef enum logic [1:0] {
        KT_TYPEMATIC  = 2'h0,
        KT_MAKE_BREAK = 2'h1,
        KT_MAKE_ONLY  = 2'h2,
        KT_TMB        = 2'h3
    } khc_ktype_t;
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_KEYS  = 4'h2,
        ST_RWAIT = 4'h4,
        ST_TEST  = 4'h8
    } khc_state_t;
    // one key type update for the set 3 table
    typedef struct packed {
        logic       valid;
        logic       all;
        khc_ktype_t ktype;
        logic [7:0] id;
    } khc_key_wr_t;
endpackage

// ===== rtl/khc_handler.sv
`timescale 1ns/1ps
`default_nettype none
`include "khc_defs.svh"
module khc_handler #(
    parameter int ACC_CYC  = `KHC_ACCEPT_CYC,
    parameter int SELF_CYC = `KHC_SELF_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 link_clk,
    input  wire logic                 rx_strobe,
    input  wire logic [7:0]           rx_byte,
    output logic                      tx_req,
    output logic [7:0]                tx_byte,
    input  wire logic                 tx_taken,
    input  wire logic                 clk_line,
    input  wire logic                 dat_line,
    input  wire logic                 self_ok,
    output logic                      scan_en,
    output logic [1:0]                scan_set,
    output logic                      buf_flush,
    output logic                      restore_dflt,
    output khc_pkg::khc_key_wr_t      key_wr,
    output logic                      other_cmd,
    output logic [7:0]                other_byte
);
    // counters are 15 and 8 bits wide, refuse counts they cannot hold
    if (ACC_CYC < 1 || ACC_CYC >= 32768 || SELF_CYC < 1 || SELF_CYC > 255) begin : g_bad_count
        $error("khc_handler: count parameter out of range");
    end

    // link side: capture bytes, present replies; reset acts on both domains
    logic       rx_tog;
    logic [7:0] rx_held;
    logic       l_s1, l_s2, l_seen;
    logic       next_rx_tog, next_l_seen, next_req;
    logic [7:0] next_rx_held, next_tx_byte;
    logic       tx_tog;
    logic [7:0] tx_hold;

    always_comb begin
        next_rx_tog  = rx_tog ^ rx_strobe;
        next_rx_held = rx_strobe ? rx_byte : rx_held;
        next_l_seen  = l_seen;
        next_req     = tx_req;
        next_tx_byte = tx_byte;
        if (tx_req && tx_taken) begin
            next_req    = 1'b0;
            next_l_seen = ~l_seen;
        end else if (!tx_req && l_s2 != l_seen) begin
            next_req     = 1'b1;
            next_tx_byte = tx_hold; // stable: tx_hold only changes together with the next toggle
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            rx_tog  <= 1'b0;
            rx_held <= 8'h00;
            l_s1    <= 1'b0;
            l_s2    <= 1'b0;
            l_seen  <= 1'b0;
            tx_req  <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            rx_tog  <= next_rx_tog;
            rx_held <= next_rx_held;
            l_s1    <= tx_tog;
            l_s2    <= l_s1;
            l_seen  <= next_l_seen;
            tx_req  <= next_req;
            tx_byte <= next_tx_byte;
        end
    end

    // main side synchronisers for toggles and line levels
    logic m_r1, m_r2, m_r3, m_a1, m_a2, c1, c2, d1, d2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {m_r1, m_r2, m_r3, m_a1, m_a2} <= 5'h00;
            {c1, c2, d1, d2} <= 4'h0;
        end else begin
            m_r1 <= rx_tog;
            m_r2 <= m_r1;
            m_r3 <= m_r2;
            m_a1 <= l_seen;
            m_a2 <= m_a1;
            c1   <= clk_line;
            c2   <= c1;
            d1   <= dat_line;
            d2   <= d1;
        end
    end

    logic       rx_new;
    logic [7:0] rx_b;
    logic       busy;
    assign rx_new = m_r2 != m_r3;
    assign rx_b   = rx_held; // held since the same link edge that flipped the toggle
    assign busy   = tx_tog != m_a2;

    khc_pkg::khc_state_t  state, next_state;
    khc_pkg::khc_key_wr_t next_key_wr;
    khc_pkg::khc_ktype_t  ksel, next_ksel;
    logic                 scan_on, next_scan_on, next_scan_en, next_flush, next_dflt, next_other, next_tx_tog;
    logic [1:0]           next_set;
    logic [14:0]          acc_cnt, next_acc;
    logic [7:0]           test_cnt, next_test, last_tx, next_last, next_hold, next_obyte, rsp;
    logic                 send, is_cmd;

    // command decoder and sequencer
    always_comb begin
        next_state   = state;
        next_scan_on = scan_on;
        next_set     = scan_set;
        next_ksel    = ksel;
        next_acc     = 15'h0000;
        next_test    = 8'h00;
        next_flush   = 1'b0;
        next_dflt    = 1'b0;
        next_other   = 1'b0;
        next_obyte   = other_byte;
        next_key_wr  = '0;
        rsp          = `KHC_RSP_ACK;
        send         = 1'b0;
        is_cmd       = rx_b >= `KHC_CMD_ECHO;
        case (state)
            khc_pkg::ST_TEST: begin
                // line activity ignored during the self check
                next_test = 8'(test_cnt + 8'h01);
                if (test_cnt == 8'(SELF_CYC - 1)) begin
                    send         = 1'b1;
                    rsp          = self_ok ? `KHC_RSP_PASS : `KHC_RSP_FAIL;
                    next_set     = `KHC_SET_POWERON;
                    next_dflt    = 1'b1;
                    next_scan_on = self_ok; // a failed check stops scanning
                    next_state   = khc_pkg::ST_RUN;
                end
            end
            default: begin
                if (state == khc_pkg::ST_RWAIT && !busy) begin
                    // acceptance: both lines high for the full window
                    next_acc = (c2 && d2) ? 15'(acc_cnt + 15'h0001) : 15'h0000;
                    if (c2 && d2 && acc_cnt == 15'(ACC_CYC - 1))
                        next_state = khc_pkg::ST_TEST;
                end
                if (rx_new && state == khc_pkg::ST_KEYS && !is_cmd) begin
                    send        = 1'b1;
                    next_key_wr = '{1'b1, 1'b0, ksel, rx_b};
                end else if (rx_new) begin
                    send       = 1'b1;
                    next_state = khc_pkg::ST_RUN;
                    if (rx_b == `KHC_CMD_DEFAULT) begin
                        next_dflt    = 1'b1;
                        next_flush   = 1'b1;
                        next_scan_on = 1'b1;
                    end else if (rx_b >= `KHC_CMD_ALL_LO && rx_b <= `KHC_CMD_ALL_HI) begin
                        next_flush   = 1'b1;
                        next_key_wr  = '{1'b1, 1'b1, khc_pkg::khc_ktype_t'(2'(rx_b[1:0] + 2'h1)), 8'h00};
                        next_scan_on = 1'b1;
                    end else if (rx_b >= `KHC_CMD_KEY_LO && rx_b <= `KHC_CMD_KEY_HI) begin
                        next_flush = 1'b1;
                        next_ksel  = khc_pkg::khc_ktype_t'(2'(rx_b[1:0] + 2'h1));
                        next_state = khc_pkg::ST_KEYS;
                    end else if (rx_b == `KHC_CMD_RESEND) begin
                        rsp = last_tx;
                    end else if (rx_b == `KHC_CMD_RESET) begin
                        next_state = khc_pkg::ST_RWAIT;
                    end else if (rx_b == `KHC_CMD_ECHO) begin
                        rsp = `KHC_RSP_ECHO;
                    end else if (!is_cmd || rx_b == `KHC_BAD_A || rx_b == `KHC_BAD_B) begin
                        rsp = `KHC_CMD_RESEND; // invalid input asks for a repeat
                    end else begin
                        next_other = 1'b1; // remaining commands belong to other logic
                        next_obyte = rx_b;
                    end
                end
            end
        endcase
        next_tx_tog = tx_tog ^ send;
        next_hold   = send ? rsp : tx_hold;
        // a resend reply never becomes the repeat source
        next_last   = (send && rsp != `KHC_CMD_RESEND) ? rsp : last_tx;
        // no scanning while reset is pending or the self check runs; registered, so glitch free
        next_scan_en = next_scan_on && (next_state == khc_pkg::ST_RUN || next_state == khc_pkg::ST_KEYS);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state        <= khc_pkg::ST_RUN;
            scan_on      <= 1'b1;
            scan_en      <= 1'b1;
            scan_set     <= `KHC_SET_POWERON;
            ksel         <= khc_pkg::KT_TYPEMATIC;
            acc_cnt      <= 15'h0000;
            test_cnt     <= 8'h00;
            buf_flush    <= 1'b0;
            restore_dflt <= 1'b0;
            other_cmd    <= 1'b0;
            other_byte   <= 8'h00;
            key_wr       <= '0;
            tx_tog       <= 1'b0;
            tx_hold      <= 8'h00;
            last_tx      <= 8'h00;
        end else begin
            state        <= next_state;
            scan_on      <= next_scan_on;
            scan_en      <= next_scan_en;
            scan_set     <= next_set;
            ksel         <= next_ksel;
            acc_cnt      <= next_acc;
            test_cnt     <= next_test;
            buf_flush    <= next_flush;
            restore_dflt <= next_dflt;
            other_cmd    <= next_other;
            other_byte   <= next_obyte;
            key_wr       <= next_key_wr;
            tx_tog       <= next_tx_tog;
            tx_hold      <= next_hold;
            last_tx      <= next_last;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic run_like;
    assign run_like = state != khc_pkg::ST_TEST && !(state == khc_pkg::ST_KEYS && !is_cmd);
    sequence s_reset_cmd;
        rx_new && run_like && rx_b == `KHC_CMD_RESET;
    endsequence
    sequence s_held_off;
        state == khc_pkg::ST_RWAIT && !scan_en && tx_hold == `KHC_RSP_ACK;
    endsequence
    a_reset_hold: assert property (s_reset_cmd |=> s_held_off) else $error("reset not held off");
    a_rwait_noscan: assert property (state == khc_pkg::ST_RWAIT |-> !scan_en) else $error("scanning in reset wait");
    a_accept_test: assert property (
        state == khc_pkg::ST_RWAIT && !busy && c2 && d2 && !rx_new && acc_cnt == 15'(ACC_CYC - 1)
        |=> state == khc_pkg::ST_TEST) else $error("acceptance missed");
    a_test_code: assert property (
        $fell(state == khc_pkg::ST_TEST) |-> scan_set == `KHC_SET_POWERON
        && tx_hold == ($past(self_ok) ? `KHC_RSP_PASS : `KHC_RSP_FAIL)) else $error("bad self check end");
    a_default_scan: assert property (
        rx_new && run_like && rx_b == `KHC_CMD_DEFAULT
        |=> restore_dflt && buf_flush && scan_on ##1 !restore_dflt) else $error("set default wrong");
    a_all_keys: assert property (
        rx_new && run_like && rx_b >= `KHC_CMD_ALL_LO && rx_b <= `KHC_CMD_ALL_HI
        |=> buf_flush && key_wr.valid && key_wr.all && tx_hold == `KHC_RSP_ACK) else $error("set all keys wrong");
    a_key_ack: assert property (
        rx_new && state == khc_pkg::ST_KEYS && !is_cmd
        |=> key_wr.valid && !key_wr.all && key_wr.ktype == $past(ksel) && tx_hold == `KHC_RSP_ACK)
        else $error("key id not typed");
    a_resend_val: assert property (
        rx_new && run_like && rx_b == `KHC_CMD_RESEND
        |=> tx_hold == $past(last_tx) && last_tx != `KHC_CMD_RESEND) else $error("resend wrong byte");
    a_keys_end: assert property (
        rx_new && state == khc_pkg::ST_KEYS && is_cmd && rx_b < `KHC_CMD_KEY_LO
        |=> state != khc_pkg::ST_KEYS) else $error("collection not ended");
    a_link_req: assert property (@(posedge link_clk) disable iff (rst)
        tx_req && !tx_taken |=> tx_req && $stable(tx_byte)) else $error("link request dropped");
endmodule // khc_handler
`default_nettype wire

// ===== verif/khc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side of the two-wire link, seen as byte strobes
module khc_host_model (
    input  wire logic       link_clk,
    input  wire logic       tx_req,
    input  wire logic [7:0] tx_byte,
    output logic            rx_strobe,
    output logic [7:0]      rx_byte,
    output logic            tx_taken,
    output logic            clk_line,
    output logic            dat_line,
    output logic            timed_out
);
    // lines held low means the controller inhibits the keyboard
    initial begin
        rx_strobe = 1'b0;
        rx_byte   = 8'h00;
        tx_taken  = 1'b0;
        clk_line  = 1'b0;
        dat_line  = 1'b0;
        timed_out = 1'b0;
    end
    // one strobe over one rising edge, then junk so a stale byte never looks valid
    task automatic send_byte(input logic [7:0] b);
        @(negedge link_clk);
        rx_byte   = b;
        rx_strobe = 1'b1;
        @(negedge link_clk);
        rx_strobe = 1'b0;
        rx_byte   = ~b;
    endtask
    // look at tx_req on falling edges where it is settled, take it over one rising edge
    task automatic get_reply(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        timed_out = 1'b0;
        @(negedge link_clk);
        while (tx_req !== 1'b1 && n < 3000) begin
            @(negedge link_clk);
            n++;
        end
        if (n >= 3000) begin
            timed_out = 1'b1;
        end else begin
            b        = tx_byte;
            tx_taken = 1'b1;
            @(negedge link_clk);
            tx_taken = 1'b0;
        end
        repeat (30) @(posedge link_clk);
    endtask
    // both lines high accepts a pending reset ack
    task automatic set_lines(input logic v);
        @(negedge link_clk);
        clk_line = v;
        dat_line = v;
    endtask
endmodule // khc_host_model
`default_nettype wire

// ===== verif/khc_handler_test.sv
`timescale 1ns/1ps
`default_nettype none
module khc_handler_test;
    logic                 clk = 1'b0;
    logic                 link_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 self_ok = 1'b1;
    logic                 rx_strobe, tx_req, tx_taken, clk_line, dat_line, host_to;
    logic [7:0]           rx_byte, tx_byte, other_byte;
    logic                 scan_en, buf_flush, restore_dflt, other_cmd;
    logic [1:0]           scan_set;
    khc_pkg::khc_key_wr_t key_wr, last_key;
    logic [7:0]           n_flush = 8'h00, n_rest = 8'h00, n_oth = 8'h00, f0, r0, o0;
    int                   errors = 0, tests_run = 0;
    always #10 clk = ~clk;
    // link clock offset so its edges never line up with clk
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    khc_handler #(.ACC_CYC(20), .SELF_CYC(16)) i_khc_handler (.clk(clk), .rst(rst), .link_clk(link_clk),
        .rx_strobe(rx_strobe), .rx_byte(rx_byte), .tx_req(tx_req), .tx_byte(tx_byte), .tx_taken(tx_taken),
        .clk_line(clk_line), .dat_line(dat_line), .self_ok(self_ok), .scan_en(scan_en), .scan_set(scan_set),
        .buf_flush(buf_flush), .restore_dflt(restore_dflt), .key_wr(key_wr), .other_cmd(other_cmd),
        .other_byte(other_byte));
    khc_host_model i_khc_host_model (.link_clk(link_clk), .tx_req(tx_req), .tx_byte(tx_byte),
        .rx_strobe(rx_strobe), .rx_byte(rx_byte), .tx_taken(tx_taken), .clk_line(clk_line),
        .dat_line(dat_line), .timed_out(host_to));
    // count one-cycle pulses so each command's side effects can be tallied
    always @(posedge clk) begin
        if (buf_flush === 1'b1) n_flush <= n_flush + 8'h01;
        if (restore_dflt === 1'b1) n_rest <= n_rest + 8'h01;
        if (other_cmd === 1'b1) n_oth <= n_oth + 8'h01;
        if (key_wr.valid === 1'b1) last_key <= key_wr;
    end
    task automatic summarize;
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reply(input logic [7:0] exp);
        logic [7:0] r;
        i_khc_host_model.get_reply(r);
        if (host_to === 1'b1) begin
            errors++;
            summarize();
        end else begin
            chk(r, exp);
        end
    endtask
    // snapshot pulse counts, send one byte, check the answer
    task automatic cmd(input logic [7:0] b, input logic [7:0] exp);
        f0 = n_flush;
        r0 = n_rest;
        o0 = n_oth;
        i_khc_host_model.send_byte(b);
        reply(exp);
    endtask
    initial begin
        logic [7:0] id;
        void'($urandom(66887));
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(posedge clk);
        chk({6'h00, scan_set}, 8'h02);
        cmd(8'hF6, 8'hFA);
        chk(n_rest - r0, 8'h01);
        chk(n_flush - f0, 8'h01);
        chk({7'h00, scan_en}, 8'h01);
        // every set-all code, type follows the command order
        for (int k = 0; k < 4; k++) begin
            cmd(8'hF7 + k[7:0], 8'hFA);
            chk(n_flush - f0, 8'h01);
            chk({5'h00, last_key.all, last_key.ktype}, {6'h01, k[1:0]});
        end
        // per-key types, ids at both ends of the valid range, echo ends collection
        for (int k = 0; k < 3; k++) begin
            cmd(8'hFB + k[7:0], 8'hFA);
            chk(n_flush - f0, 8'h01);
            for (int j = 0; j < 3; j++) begin
                id = (j == 0) ? 8'hED : ((j == 1) ? 8'h00 : 8'($urandom_range(0, 237)));
                cmd(id, 8'hFA);
                chk(last_key.id, id);
                chk({5'h00, last_key.all, last_key.ktype}, {6'h00, k[1:0]});
            end
            cmd(8'hEE, 8'hEE);
        end
        // resend repeats, and skips over the keyboard's own resend reply
        cmd(8'hFE, 8'hEE);
        cmd(8'hFE, 8'hEE);
        cmd(8'hEF, 8'hFE);
        cmd(8'hFE, 8'hEE);
        // commands for other logic are acked and forwarded once each
        for (int k = 0; k < 6; k++) begin
            if (k != 1) begin
                cmd(8'hF0 + k[7:0], 8'hFA);
                chk(other_byte, 8'hF0 + k[7:0]);
                chk(n_oth - o0, 8'h01);
            end
        end
        // unsupported code and a stray byte ask for a repeat, nothing forwarded
        cmd(8'hF1, 8'hFE);
        cmd(8'($urandom_range(0, 237)), 8'hFE);
        chk(n_oth - o0, 8'h00);
        // reset with passing then failing self check
        for (int k = 0; k < 2; k++) begin
            @(negedge clk) self_ok = (k == 0);
            cmd(8'hFF, 8'hFA);
            repeat (60) @(posedge clk);
            chk({7'h00, scan_en}, 8'h00);
            // two short highs must not add up to acceptance
            for (int j = 0; j < 2; j++) begin
                i_khc_host_model.set_lines(1'b1);
                repeat (15) @(posedge clk);
                i_khc_host_model.set_lines(1'b0);
                repeat (5) @(posedge clk);
            end
            repeat (40) @(posedge clk);
            chk({7'h00, scan_en}, 8'h00);
            i_khc_host_model.set_lines(1'b1);
            reply((k == 0) ? 8'hAA : 8'hFC);
            i_khc_host_model.set_lines(1'b0);
            chk({6'h00, scan_set}, 8'h02);
            chk({7'h00, scan_en}, {7'h00, self_ok});
        end
        // a later command overrides a pending reset
        cmd(8'hFF, 8'hFA);
        cmd(8'hF6, 8'hFA);
        chk({7'h00, scan_en}, 8'h01);
        summarize();
    end
endmodule // khc_handler_test
`default_nettype wire
